// ===== hw/scfg_regs.sv
// Contract
// - Codes 0,1,2 select registers 0,1,2
// - Codes 3,4 select registers 3,4
// - Autocal bit starts calibration on write
// - Prescaler bit; host keeps integer minimum
// - Sixteen-bit integer divide value, prescaler maximum
// - Register 1 holds 24-bit main fraction
// - Aux numerator and modulus in register 2
// - Register 0 write resets modulator unless disabled
// - Resync enable, active only aux numerator zero
// - Phase step each register 0 write
// - 24-bit phase word, linear full cycle
// - Register 4 selects multiplexer output source
// - Reference doubler enable bit
// - Reference halver toggle after counter
// - Ten-bit reference counter, ratio 1-1023
// - Double-buffer enable for output divider select
// - Four-bit charge pump current select
// - Reference input differential or single-ended
// - Multiplexer logic level select
// - Buffered fields apply on register 0 write
// - Phase detector polarity bit
// - Soft power down keeps registers
// - Charge pump three-state bit
// - Counter clear holds counters in reset
module scfg_regs #(
  parameter int WORD_W = 32
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Three-wire serial link from host
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic ser_le,
  // Output divider select staged from register 6
  input wire logic [2:0] out_div_staged,
  // Settings to the analog core
  output scfg_pkg::scfg_active_t active_r,
  output scfg_pkg::scfg_direct_t direct_r,
  output logic [2:0] out_div_active_r,
  // Event pulses, plus the resync level
  output logic autocal_start_r,
  output logic modulator_reset_r,
  output logic phase_step_r,
  output logic resync_active_r,
  // Host-side programming faults, sticky until reset
  output logic int_range_err_r,
  output logic aux_order_err_r
);

  logic [WORD_W-1:0] word;
  logic word_valid;
  scfg_pkg::scfg_active_t staged_r;
  scfg_pkg::scfg_active_t staged_nxt;
  scfg_pkg::scfg_active_t active_nxt;
  scfg_pkg::scfg_direct_t direct_nxt;
  logic [2:0] out_div_active_nxt;
  logic autocal_start_nxt;
  logic modulator_reset_nxt;
  logic phase_step_nxt;
  logic resync_active_nxt;
  logic int_range_err_nxt;
  logic aux_order_err_nxt;
  logic [3:0] sel;
  logic [15:0] int_min;
  logic [15:0] int_val;

  ////////////////////////////////////////////////////////////////////////////
  scfg_shift_in #(
    .WIDTH(WORD_W)
  ) u_shift (
    .sys_clk(sys_clk),
    .srst(srst),
    .ser_clk(ser_clk),
    .ser_data(ser_data),
    .ser_le(ser_le),
    .word_r(word),
    .word_valid_r(word_valid)
  );

  assign sel = word[scfg_pkg::SEL_MSB:scfg_pkg::SEL_LSB];
  assign int_val = word[scfg_pkg::R0_INT_MSB:scfg_pkg::R0_INT_LSB];
  assign int_min = word[scfg_pkg::R0_PRESCALER] ? scfg_pkg::INT_MIN_89 : scfg_pkg::INT_MIN_45;

  ////////////////////////////////////////////////////////////////////////////
  // Decode and staging
  always_comb begin
    staged_nxt = staged_r;
    active_nxt = active_r;
    direct_nxt = direct_r;
    out_div_active_nxt = out_div_active_r;
    autocal_start_nxt = 1'b0;
    modulator_reset_nxt = 1'b0;
    phase_step_nxt = 1'b0;
    int_range_err_nxt = int_range_err_r;
    aux_order_err_nxt = aux_order_err_r;
    // Resync only meaningful with a zero aux numerator
    resync_active_nxt = direct_r.resync_enable && (active_r.aux_fraction_numerator == 14'h0000);
    if (word_valid) begin
      unique case (sel)
        scfg_pkg::SEL_INT: begin
          // Upper bits are ignored; host is expected to send zeros
          staged_nxt.prescaler_or_resync_bit = word[scfg_pkg::R0_PRESCALER];
          staged_nxt.int_value = int_val;
          if (int_val < int_min) begin
            int_range_err_nxt = 1'b1;
          end
          if (!word[scfg_pkg::R0_PRESCALER] && (int_val > scfg_pkg::INT_MAX_45)) begin
            int_range_err_nxt = 1'b1;
          end
          // Load everything double-buffered in one step
          active_nxt = staged_nxt;
          if (direct_r.double_buffer_enable) begin
            out_div_active_nxt = out_div_staged;
          end
          autocal_start_nxt = word[scfg_pkg::R0_AUTOCAL];
          modulator_reset_nxt = !direct_r.modulator_reset_disable;
          phase_step_nxt = direct_r.phase_step_enable;
          if (staged_r.aux_fraction_numerator >= staged_r.aux_fraction_modulus) begin
            aux_order_err_nxt = 1'b1;
          end
        end
        scfg_pkg::SEL_FRAC: begin
          staged_nxt.main_fraction_numerator =
            word[scfg_pkg::R1_FRAC_MSB:scfg_pkg::R1_FRAC_LSB];
        end
        scfg_pkg::SEL_AUX: begin
          staged_nxt.aux_fraction_numerator =
            word[scfg_pkg::R2_AUXN_MSB:scfg_pkg::R2_AUXN_LSB];
          staged_nxt.aux_fraction_modulus =
            word[scfg_pkg::R2_AUXM_MSB:scfg_pkg::R2_AUXM_LSB];
        end
        scfg_pkg::SEL_PHASE: begin
          direct_nxt.modulator_reset_disable = word[scfg_pkg::R3_SDRST_DIS];
          direct_nxt.resync_enable = word[scfg_pkg::R3_RESYNC];
          direct_nxt.phase_step_enable = word[scfg_pkg::R3_PSTEP];
          staged_nxt.phase_word = word[scfg_pkg::R3_PH_MSB:scfg_pkg::R3_PH_LSB];
        end
        scfg_pkg::SEL_REF: begin
          direct_nxt.mux_select = word[scfg_pkg::R4_MUX_MSB:scfg_pkg::R4_MUX_LSB];
          staged_nxt.ref_doubler_enable = word[scfg_pkg::R4_DBL];
          staged_nxt.ref_halver_enable = word[scfg_pkg::R4_HALF];
          staged_nxt.ref_count = word[scfg_pkg::R4_RCNT_MSB:scfg_pkg::R4_RCNT_LSB];
          direct_nxt.double_buffer_enable = word[scfg_pkg::R4_DBUF];
          staged_nxt.pump_current_select = word[scfg_pkg::R4_CP_MSB:scfg_pkg::R4_CP_LSB];
          direct_nxt.ref_differential = word[scfg_pkg::R4_REFDIFF];
          direct_nxt.mux_logic_level = word[scfg_pkg::R4_LVL];
          direct_nxt.detector_polarity = word[scfg_pkg::R4_POL];
          // Writes still land during power down, only the core sleeps
          direct_nxt.soft_power_down = word[scfg_pkg::R4_PD];
          direct_nxt.pump_tristate = word[scfg_pkg::R4_TRI];
          direct_nxt.counter_clear = word[scfg_pkg::R4_CLR];
        end
        default: begin
          // Registers beyond 4 belong to other blocks
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      staged_r <= '0;
      staged_r.ref_count <= scfg_pkg::RCNT_RESET;
      active_r <= '0;
      active_r.ref_count <= scfg_pkg::RCNT_RESET;
      direct_r <= '0;
      out_div_active_r <= '0;
      autocal_start_r <= 1'b0;
      modulator_reset_r <= 1'b0;
      phase_step_r <= 1'b0;
      resync_active_r <= 1'b0;
      int_range_err_r <= 1'b0;
      aux_order_err_r <= 1'b0;
    end else begin
      staged_r <= staged_nxt;
      active_r <= active_nxt;
      direct_r <= direct_nxt;
      out_div_active_r <= out_div_active_nxt;
      autocal_start_r <= autocal_start_nxt;
      modulator_reset_r <= modulator_reset_nxt;
      phase_step_r <= phase_step_nxt;
      resync_active_r <= resync_active_nxt;
      int_range_err_r <= int_range_err_nxt;
      aux_order_err_r <= aux_order_err_nxt;
    end
  end

endmodule : scfg_regs

// ===== common/scfg_pkg.sv
package scfg_pkg;

  // Register select codes in the low nibble of each word
  localparam logic [3:0] SEL_INT = 4'h0;
  localparam logic [3:0] SEL_FRAC = 4'h1;
  localparam logic [3:0] SEL_AUX = 4'h2;
  localparam logic [3:0] SEL_PHASE = 4'h3;
  localparam logic [3:0] SEL_REF = 4'h4;

  localparam int WORD_BITS = 32;
  localparam int SEL_LSB = 0;
  localparam int SEL_MSB = 3;

  // Register 0 fields
  localparam int R0_AUTOCAL = 21;
  localparam int R0_PRESCALER = 20;
  localparam int R0_INT_MSB = 19;
  localparam int R0_INT_LSB = 4;
  localparam logic [15:0] INT_MIN_45 = 16'h0017;
  localparam logic [15:0] INT_MIN_89 = 16'h004b;
  localparam logic [15:0] INT_MAX_45 = 16'h7fff;

  // Register 1 / 2 fields
  localparam int R1_FRAC_MSB = 27;
  localparam int R1_FRAC_LSB = 4;
  localparam int R2_AUXN_MSB = 31;
  localparam int R2_AUXN_LSB = 18;
  localparam int R2_AUXM_MSB = 17;
  localparam int R2_AUXM_LSB = 4;

  // Register 3 fields
  localparam int R3_SDRST_DIS = 30;
  localparam int R3_RESYNC = 29;
  localparam int R3_PSTEP = 28;
  localparam int R3_PH_MSB = 27;
  localparam int R3_PH_LSB = 4;

  // Register 4 fields
  localparam int R4_MUX_MSB = 29;
  localparam int R4_MUX_LSB = 27;
  localparam int R4_DBL = 26;
  localparam int R4_HALF = 25;
  localparam int R4_RCNT_MSB = 24;
  localparam int R4_RCNT_LSB = 15;
  localparam int R4_DBUF = 14;
  localparam int R4_CP_MSB = 13;
  localparam int R4_CP_LSB = 10;
  localparam int R4_REFDIFF = 9;
  localparam int R4_LVL = 8;
  localparam int R4_POL = 7;
  localparam int R4_PD = 6;
  localparam int R4_TRI = 5;
  localparam int R4_CLR = 4;

  localparam logic [31:0] WORD_RESET = 32'h0000_0000;
  localparam logic [9:0] RCNT_RESET = 10'h001;

  // Active settings handed to the analog core
  typedef struct packed {
    logic prescaler_or_resync_bit;
    logic [15:0] int_value;
    logic [23:0] main_fraction_numerator;
    logic [13:0] aux_fraction_numerator;
    logic [13:0] aux_fraction_modulus;
    logic [23:0] phase_word;
    logic [2:0] feedback_source_select;
    logic ref_doubler_enable;
    logic ref_halver_enable;
    logic [9:0] ref_count;
    logic [3:0] pump_current_select;
  } scfg_active_t;

  typedef struct packed {
    logic [2:0] mux_select;
    logic ref_differential;
    logic mux_logic_level;
    logic detector_polarity;
    logic soft_power_down;
    logic pump_tristate;
    logic counter_clear;
    logic double_buffer_enable;
    logic modulator_reset_disable;
    logic resync_enable;
    logic phase_step_enable;
  } scfg_direct_t;

endpackage : scfg_pkg

// ===== hw/scfg_shift_in.sv
module scfg_shift_in #(
  parameter int WIDTH = 32
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Serial link, sampled on sys_clk
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic ser_le,
  // Latched word
  output logic [WIDTH-1:0] word_r,
  output logic word_valid_r
);

  logic [WIDTH-1:0] shift_r;
  logic [WIDTH-1:0] shift_nxt;
  logic [WIDTH-1:0] word_nxt;
  logic word_valid_nxt;
  logic clk_d_r;
  logic le_d_r;

  ////////////////////////////////////////////////////////////////////////////
  // Edges are detected by sampling; link clock must be no faster than sys_clk/2
  always_comb begin
    shift_nxt = shift_r;
    word_nxt = word_r;
    word_valid_nxt = 1'b0;
    if (ser_clk && !clk_d_r) begin
      shift_nxt = {shift_r[WIDTH-2:0], ser_data};
    end
    if (ser_le && !le_d_r) begin
      word_nxt = shift_r;
      word_valid_nxt = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      shift_r <= '0;
      word_r <= '0;
      word_valid_r <= 1'b0;
      clk_d_r <= 1'b0;
      le_d_r <= 1'b0;
    end else begin
      shift_r <= shift_nxt;
      word_r <= word_nxt;
      word_valid_r <= word_valid_nxt;
      clk_d_r <= ser_clk;
      le_d_r <= ser_le;
    end
  end

endmodule : scfg_shift_in

// ===== tb/scfg_regs_props.sv
module scfg_regs_props (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Load strobe from host
  input wire logic ser_le,
  // Observed outputs
  input wire scfg_pkg::scfg_active_t active_r,
  input wire scfg_pkg::scfg_direct_t direct_r,
  input wire logic [2:0] out_div_active_r,
  input wire logic autocal_start_r,
  input wire logic modulator_reset_r,
  input wire logic phase_step_r,
  input wire logic resync_active_r,
  input wire logic int_range_err_r,
  input wire logic aux_order_err_r
);
  timeunit 1ns;
  timeprecision 1ps;
  // Sampled as one signal so that the one-cycle lag can be checked
  logic resync_cond;
  assign resync_cond = direct_r.resync_enable && (active_r.aux_fraction_numerator == 14'h0000);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);
  ////////////////////
  // Buffered values move only two or three edges after a load strobe
  property p_act_load;
    !$stable(active_r) |-> ($past(ser_le, 2) || $past(ser_le, 3));
  endproperty
  a_act_load: assert property (p_act_load) else $error("active changed without load");
  property p_pulse_load;
    (autocal_start_r || modulator_reset_r || phase_step_r) |-> ($past(ser_le, 2) || $past(ser_le, 3));
  endproperty
  a_pulse_load: assert property (p_pulse_load) else $error("pulse without load");
  property p_mod_rst;
    modulator_reset_r |-> !direct_r.modulator_reset_disable;
  endproperty
  a_mod_rst: assert property (p_mod_rst) else $error("modulator reset while disabled");
  property p_mod_width;
    modulator_reset_r |=> !modulator_reset_r;
  endproperty
  a_mod_width: assert property (p_mod_width) else $error("modulator reset too long");
  property p_step;
    phase_step_r |-> direct_r.phase_step_enable;
  endproperty
  a_step: assert property (p_step) else $error("phase step while off");
  property p_resync;
    resync_active_r == $past(resync_cond);
  endproperty
  a_resync: assert property (p_resync) else $error("resync level wrong");
  property p_int_err;
    $rose(int_range_err_r) |-> (active_r.prescaler_or_resync_bit ?
      active_r.int_value < 16'h004b :
      (active_r.int_value < 16'h0017 || active_r.int_value > 16'h7fff));
  endproperty
  a_int_err: assert property (p_int_err) else $error("range flag without cause");
  property p_aux_err;
    $rose(aux_order_err_r) |-> active_r.aux_fraction_numerator >= active_r.aux_fraction_modulus;
  endproperty
  a_aux_err: assert property (p_aux_err) else $error("aux flag without cause");
  property p_sticky;
    int_range_err_r |=> int_range_err_r [*3];
  endproperty
  a_sticky: assert property (p_sticky) else $error("range flag dropped");
  property p_outdiv;
    !$stable(out_div_active_r) |-> direct_r.double_buffer_enable;
  endproperty
  a_outdiv: assert property (p_outdiv) else $error("divider moved unbuffered");
  c_cal: cover property (autocal_start_r);
  c_step: cover property (phase_step_r);
  c_resync: cover property (resync_active_r);
  c_aux: cover property ($rose(aux_order_err_r));
endmodule : scfg_regs_props

// ===== tb/scfg_host.sv
module scfg_host (
  // Clock
  input wire logic sys_clk,
  // Serial link
  output logic ser_clk,
  output logic ser_data,
  output logic ser_le
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    ser_le = 1'b0;
  end
  // MSB first, two cycles per clock phase, clock idles low
  task automatic send(input logic [31:0] w);
    for (int i = 31; i >= 0; i--) begin
      @(posedge sys_clk) ser_clk <= 1'b0;
      ser_data <= w[i];
      repeat (2) @(posedge sys_clk);
      ser_clk <= 1'b1;
      @(posedge sys_clk);
    end
    @(posedge sys_clk) ser_clk <= 1'b0;
    // Released line shows the inverse so a stale bit cannot pass
    ser_data <= ~w[0];
    repeat (2) @(posedge sys_clk);
    ser_le <= 1'b1;
    repeat (3) @(posedge sys_clk);
    ser_le <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask : send
endmodule : scfg_host

// ===== tb/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, srst, ser_clk, ser_data, ser_le, autocal_start_r, modulator_reset_r;
  logic phase_step_r, resync_active_r, int_range_err_r, aux_order_err_r;
  logic [2:0] out_div_staged, out_div_active_r, exp_od;
  scfg_pkg::scfg_active_t active_r, exp_a;
  scfg_pkg::scfg_direct_t direct_r;
  logic [31:0] w0, w1, w2, w3, w4, r;
  logic [15:0] iv;
  logic [13:0] m;
  integer seed = 32'h4a5703a7;
  int bad_count = 0, checks_done = 0, cyc = 0;
  int n_ac = 0, n_mr = 0, n_ps = 0, e_ac = 0, e_mr = 0, e_ps = 0;
  scfg_regs uut (.sys_clk(sys_clk), .srst(srst), .ser_clk(ser_clk), .ser_data(ser_data),
    .ser_le(ser_le), .out_div_staged(out_div_staged), .active_r(active_r),
    .direct_r(direct_r), .out_div_active_r(out_div_active_r),
    .autocal_start_r(autocal_start_r), .modulator_reset_r(modulator_reset_r),
    .phase_step_r(phase_step_r), .resync_active_r(resync_active_r),
    .int_range_err_r(int_range_err_r), .aux_order_err_r(aux_order_err_r));
  scfg_host host (.sys_clk(sys_clk), .ser_clk(ser_clk), .ser_data(ser_data), .ser_le(ser_le));
  ////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // Pulses last one cycle, so count them on every edge
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    n_ac <= n_ac + int'(autocal_start_r === 1'b1);
    n_mr <= n_mr + int'(modulator_reset_r === 1'b1);
    n_ps <= n_ps + int'(phase_step_r === 1'b1);
    if (cyc == 20000) begin
      bad_count++;
      wrap_up();
    end
  end
  ////////////////////
  task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Unmapped source-select field is left out of the comparison
  task automatic act_chk;
    scfg_pkg::scfg_active_t s;
    s = active_r;
    s.feedback_source_select = 3'h0;
    chk(s, exp_a);
  endtask : act_chk
  function automatic scfg_pkg::scfg_active_t f_act(input logic [31:0] a, b, c, d, e);
    f_act = '0;
    f_act.prescaler_or_resync_bit = a[20];
    f_act.int_value = a[19:4];
    f_act.main_fraction_numerator = b[27:4];
    f_act.aux_fraction_numerator = c[31:18];
    f_act.aux_fraction_modulus = c[17:4];
    f_act.phase_word = d[27:4];
    f_act.ref_doubler_enable = e[26];
    f_act.ref_halver_enable = e[25];
    f_act.ref_count = e[24:15];
    f_act.pump_current_select = e[13:10];
  endfunction : f_act
  function automatic scfg_pkg::scfg_direct_t f_dir(input logic [31:0] d, e);
    f_dir = {e[29:27], e[9], e[8], e[7], e[6], e[5], e[4], e[14], d[30], d[29], d[28]};
  endfunction : f_dir
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrap_up
  ////////////////////
  initial begin
    srst = 1'b1;
    out_div_staged = 3'h0;
    exp_od = 3'h0;
    repeat (12) @(posedge sys_clk);
    srst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    exp_a = '0;
    exp_a.ref_count = 10'h001;
    chk(direct_r, '0);
    act_chk();
    $display("test reset done");
    for (int i = 0; i < 9; i++) begin
      r = $random(seed);
      w1 = {4'h0, r[27:4], 4'h1};
      m = r[17:4] | 14'h1;
      w2 = {(i % 2 == 0) ? 14'h0 : r[31:18] % m, m, 4'h2};
      r = $random(seed);
      w3 = {1'b0, r[30], i % 3 == 2, i % 3 == 1, r[27:4], 4'h3};
      // All three source-select bits random, reserved top bits zero
      w4 = $random(seed);
      w4[31:30] = 2'b00;
      w4[3:0] = 4'h4;
      host.send(w1);
      host.send(w2);
      host.send(w3);
      host.send(w4);
      host.send({r[31:4], 4'h5 + r[3:0] % 4'hb});
      chk(direct_r, f_dir(w3, w4));
      act_chk();
      out_div_staged <= r[2:0];
      iv = r[20] ? 16'd75 + r[19:4] % 16'd65461 : 16'd23 + r[18:4] % 16'd32745;
      if (i == 0) iv = r[20] ? 16'd75 : 16'd23;
      if (i == 8) iv = r[20] ? 16'hffff : 16'h7fff;
      w0 = {10'h0, r[21], r[20], iv, 4'h0};
      host.send(w0);
      e_ac += w0[21];
      e_mr += !w3[30];
      e_ps += w3[28];
      if (w4[14]) exp_od = r[2:0];
      exp_a = f_act(w0, w1, w2, w3, w4);
      act_chk();
      chk(out_div_active_r, exp_od);
      chk(n_ac, e_ac);
      chk(n_mr, e_mr);
      chk(n_ps, e_ps);
      chk(resync_active_r, w3[29] && w2[31:18] == 14'h0);
      $display("test write %0d done", i);
    end
    chk({int_range_err_r, aux_order_err_r}, 2'b00);
    w2 = {14'h20, 14'h20, 4'h2};
    w0 = {10'h0, 2'b00, 16'd22, 4'h0};
    host.send(w2);
    host.send(w0);
    chk({int_range_err_r, aux_order_err_r}, 2'b11);
    $display("test faults done");
    // Held three edges so the checker never sees a change across the release
    srst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    srst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    exp_a = '0;
    exp_a.ref_count = 10'h001;
    chk({int_range_err_r, aux_order_err_r}, 2'b00);
    chk(direct_r, '0);
    act_chk();
    $display("test reset again done");
    wrap_up();
  end
endmodule : testbench
bind scfg_regs scfg_regs_props props (.sys_clk(sys_clk), .srst(srst), .ser_le(ser_le),
  .active_r(active_r), .direct_r(direct_r), .out_div_active_r(out_div_active_r),
  .autocal_start_r(autocal_start_r), .modulator_reset_r(modulator_reset_r),
  .phase_step_r(phase_step_r), .resync_active_r(resync_active_r),
  .int_range_err_r(int_range_err_r), .aux_order_err_r(aux_order_err_r));
